// file: verilog/flash_front_pkg.sv
package flash_front_pkg;

    localparam int          PAGE_BITS      = 11;
    localparam int          BYTE_BITS      = 9;
    localparam int          DUMMY_BITS     = 4;
    localparam int          ADDR_BITS      = 24;
    localparam int          PAGE_LSB       = 9;
    localparam int          BYTE_LSB       = 0;
    localparam int          CLK_MHZ        = 40;
    localparam int          SELECT_WAIT_US = 70;
    localparam int          PROGRAM_WAIT_MS = 3;
    localparam int          SELECT_WAIT_CYC = SELECT_WAIT_US * CLK_MHZ;
    localparam int          PROGRAM_WAIT_CYC =
                                PROGRAM_WAIT_MS * 1000 * CLK_MHZ;
    localparam logic [7:0]  OP_PAGE_PROG   = 8'h82;
    localparam logic [7:0]  OP_BUF_WRITE1  = 8'h84;
    localparam logic [7:0]  OP_BUF_WRITE2  = 8'h87;
    localparam logic [7:0]  OP_BUF_READ1   = 8'hD1;
    localparam logic [7:0]  OP_BUF_READ2   = 8'hD3;
    localparam logic [7:0]  OP_BUF_READ3   = 8'hD4;
    localparam logic [7:0]  OP_BUF_READ4   = 8'hD6;
    localparam logic [7:0]  OP_FAST_READ   = 8'h0B;
    localparam logic [7:0]  OP_FAST_READ2  = 8'h1B;
    localparam logic [7:0]  OP_MAIN_READ   = 8'hD2;
    localparam logic [2:0]  DUMMY_NONE     = 3'h0;
    localparam logic [2:0]  DUMMY_ONE      = 3'h1;
    localparam logic [2:0]  DUMMY_TWO      = 3'h2;
    localparam logic [2:0]  DUMMY_FOUR     = 3'h4;
    localparam logic        MODE3          = 1'b1;

    typedef enum logic [1:0] {
        PWR_RESET,
        PWR_STANDBY,
        PWR_ACTIVE
    } pwr_state_type;

    // Buffer-only opcodes leave the whole page field as dummy bits
    function automatic logic buffer_only(input logic [7:0] op);
        buffer_only = (op == OP_BUF_WRITE1) || (op == OP_BUF_WRITE2) ||
                      (op == OP_BUF_READ1) || (op == OP_BUF_READ2) ||
                      (op == OP_BUF_READ3) || (op == OP_BUF_READ4);
    endfunction : buffer_only

    function automatic logic [2:0] extra_dummy(input logic [7:0] op);
        case (op)
            OP_FAST_READ, OP_BUF_READ3, OP_BUF_READ4: extra_dummy = DUMMY_ONE;
            OP_FAST_READ2: extra_dummy = DUMMY_TWO;
            OP_MAIN_READ:  extra_dummy = DUMMY_FOUR;
            default:       extra_dummy = DUMMY_NONE;
        endcase
    endfunction : extra_dummy

endpackage : flash_front_pkg

// file: verilog/cmd_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cmd_link_if;
    logic        frame_tgl;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic        mode;
    modport link (output frame_tgl, output opcode, output addr, output mode);
    modport core (input frame_tgl, input opcode, input addr, input mode);
endinterface : cmd_link_if
`default_nettype wire

// file: verilog/spi_cmd_shifter.sv
`timescale 1ns/100ps
`default_nettype none
module spi_cmd_shifter
    import flash_front_pkg::*;
(
    input  wire logic   i_sck,
    input  wire logic   i_cs_n,
    input  wire logic   i_si,
    input  wire logic   i_rst_n,
    cmd_link_if.link    lnk
);
    // Runs only while the frame clocks; state is cleared by the frame itself
    logic [5:0]  count_q;
    logic [31:0] shift_q;
    logic        tgl_q;

    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            count_q <= 6'h00;
            shift_q <= 32'h0000_0000;
        end else begin
            shift_q <= {shift_q[30:0], i_si};
            if (count_q != 6'h20) begin
                count_q <= count_q + 6'h01;
            end
        end
    end

    // Word is published once all four bytes are in; fields are stable
    // until the next toggle, so the core may sample them after syncing.
    // Reset must be released while the link clock stands still.
    always_ff @(posedge i_sck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lnk.opcode <= 8'h00;
            lnk.addr   <= 24'h00_0000;
            tgl_q      <= 1'b0;
        end else if (!i_cs_n && count_q == 6'h1F) begin
            lnk.opcode <= shift_q[30:23];
            lnk.addr   <= {shift_q[22:0], i_si};
            tgl_q      <= ~tgl_q;
        end
    end

    // Clock idle level latched at the select edge
    always_ff @(negedge i_cs_n) begin
        lnk.mode <= i_sck;
    end

    assign lnk.frame_tgl = tgl_q;

endmodule : spi_cmd_shifter
`default_nettype wire

// file: verilog/flash_cmd_front.sv
// Operation
// - Page opcodes: four dummy, eleven page, nine byte bits; buffer opcodes dummy page.
// - Page field eleven bits, byte field nine bits, most significant first.
// - After power-up or reset the clock mode is mode 3.
// - Data output stays undriven after reset until a command needs it.
// - Each select falling edge outside power-on reset samples clock idle level to pick mode.
// - During power-on reset all commands are ignored.
// - After power-up the device sits in standby.
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_front
    import flash_front_pkg::*;
#(
    parameter int SELECT_WAIT  = SELECT_WAIT_CYC,
    parameter int PROGRAM_WAIT = PROGRAM_WAIT_CYC
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_sck,
    input  wire logic                  i_cs_n,
    input  wire logic                  i_si,
    input  wire logic                  i_data_req,
    output logic                       o_so,
    output logic                       o_so_oe,
    output logic                       o_cmd_valid,
    output logic [7:0]                 o_opcode,
    output logic [PAGE_BITS-1:0]       o_page_addr_bit,
    output logic [BYTE_BITS-1:0]       o_byte_addr,
    output logic [2:0]                 o_extra_dummy,
    output logic                       o_buffer_only,
    output logic                       o_mode3,
    output logic                       o_standby,
    output logic                       o_program_ok
);
    import flash_front_pkg::*;

    // Counts the counter cannot serve, or a field split that does not
    // fill the address word, are refused at elaboration
    if (SELECT_WAIT < 1 || PROGRAM_WAIT < SELECT_WAIT) begin : g_bad_wait
        $error("flash_cmd_front: wait counts out of range");
    end
    if (DUMMY_BITS + PAGE_BITS + BYTE_BITS != ADDR_BITS) begin : g_bad_split
        $error("flash_cmd_front: address fields do not fill the word");
    end
    if (PAGE_LSB != BYTE_LSB + BYTE_BITS) begin : g_bad_lsb
        $error("flash_cmd_front: page field must sit above byte field");
    end

    // Reset is asserted at once and released two clocks later, so every
    // register leaves reset on the same edge
    logic        rst_a_q;
    logic        rst_b_q;
    logic        rst_n;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_b_q <= rst_a_q;
        end
    end
    assign rst_n = rst_b_q;

    // The link side takes the same reset so that its toggle and the
    // synchroniser below start out equal
    cmd_link_if lnk ();
    spi_cmd_shifter u_shift (
        .i_sck   (i_sck),
        .i_cs_n  (i_cs_n),
        .i_si    (i_si),
        .i_rst_n (rst_n),
        .lnk     (lnk.link)
    );

    // Three stages; a change counts only once the last two agree
    logic [2:0]  tgl_sync_q;
    logic [2:0]  cs_sync_q;
    logic        tgl_seen_q;
    logic        cs_stable_q;
    logic        cs_prev_q;
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_sync_q  <= 3'h0;
            cs_sync_q   <= 3'h7;
            tgl_seen_q  <= 1'b0;
            cs_stable_q <= 1'b1;
            cs_prev_q   <= 1'b1;
        end else begin
            tgl_sync_q <= {tgl_sync_q[1:0], lnk.frame_tgl};
            cs_sync_q  <= {cs_sync_q[1:0], i_cs_n};
            if (tgl_sync_q[1] == tgl_sync_q[2]) begin
                tgl_seen_q <= tgl_sync_q[2];
            end
            if (cs_sync_q[1] == cs_sync_q[2]) begin
                cs_stable_q <= cs_sync_q[2];
            end
            cs_prev_q <= cs_stable_q;
        end
    end

    // A new word shows as a settled toggle that differs from the last seen
    logic        word_evt;
    logic        cs_fall;
    assign word_evt = (tgl_sync_q[2] == tgl_sync_q[1]) &&
                      (tgl_sync_q[2] != tgl_seen_q);
    assign cs_fall  = cs_prev_q && !cs_stable_q;

    pwr_state_type state_q;
    logic [31:0]   wait_q;
    logic          armed_q;

    // Counts from reset release and then sticks, so the program gate
    // cannot wrap back to closed in a long run
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 32'h0000_0000;
        end else if (wait_q != 32'hFFFF_FFFF) begin
            wait_q <= wait_q + 32'h0000_0001;
        end
    end

    // Commands are ignored until the hold-off has run out
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PWR_RESET;
        end else begin
            case (state_q)
                PWR_RESET: begin
                    if (wait_q >= 32'(SELECT_WAIT)) begin
                        state_q <= PWR_STANDBY;
                    end
                end
                PWR_STANDBY: begin
                    if (cs_fall && armed_q) begin
                        state_q <= PWR_ACTIVE;
                    end
                end
                PWR_ACTIVE: begin
                    if (cs_stable_q) begin
                        state_q <= PWR_STANDBY;
                    end
                end
                default: state_q <= PWR_RESET;
            endcase
        end
    end

    // A select already low when reset ends must rise and fall again
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (state_q != PWR_RESET && cs_stable_q) begin
            armed_q <= 1'b1;
        end
    end

    // A word is taken only while a properly framed command is open
    logic        take_word;
    assign take_word = word_evt && (state_q == PWR_ACTIVE);

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_cmd_valid <= 1'b0;
        end else begin
            o_cmd_valid <= take_word;
        end
    end

    // Fields are held until the next taken word, so a slow consumer
    // can still read them well after the strobe
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_opcode        <= 8'h00;
            o_page_addr_bit <= '0;
            o_byte_addr     <= '0;
            o_extra_dummy   <= DUMMY_NONE;
            o_buffer_only   <= 1'b0;
        end else if (take_word) begin
            o_opcode      <= lnk.opcode;
            o_extra_dummy <= extra_dummy(lnk.opcode);
            o_buffer_only <= buffer_only(lnk.opcode);
            o_byte_addr   <= lnk.addr[BYTE_LSB +: BYTE_BITS];
            // Top four bits are never looked at
            o_page_addr_bit <= buffer_only(lnk.opcode) ? '0 :
                lnk.addr[PAGE_LSB +: PAGE_BITS];
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_mode3 <= MODE3;
        end else if (cs_fall && state_q != PWR_RESET) begin
            o_mode3 <= lnk.mode;
        end
    end

    // Output stays released until i_data_req asks for data while a command's select is low
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_so_oe <= 1'b0;
        end else begin
            o_so_oe <= (state_q == PWR_ACTIVE) && i_data_req &&
                       !cs_stable_q;
        end
    end

    // No data path sits behind the pin here; a driven pin shows low
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_so <= 1'b0;
        end else begin
            o_so <= 1'b0;
        end
    end

    assign o_standby    = (state_q == PWR_STANDBY);
    assign o_program_ok = (wait_q >= 32'(PROGRAM_WAIT));

endmodule : flash_cmd_front
`default_nettype wire

// file: dv/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si
);
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b1;
        o_si   = 1'b0;
    end
    // Clock only toggles inside a frame; idle level tells the mode
    task automatic frame(input logic m3, input logic [31:0] w);
        o_sck = m3;
        #100 o_cs_n = 1'b0;
        #300;
        for (int i = 31; i >= 0; i--) begin
            o_sck = 1'b0;
            o_si  = w[i];
            #7.5 o_sck = 1'b1;
            #7.5;
        end
        o_sck = m3;
        #100 o_cs_n = 1'b1;
        o_si = ~o_si;
        #200;
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

// file: dv/flash_cmd_front_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_front_assertions
    import flash_front_pkg::*;
#(
    parameter int SELECT_WAIT  = 8,
    parameter int PROGRAM_WAIT = 20
) (
    input wire logic                 i_mclk,
    input wire logic                 i_rst_n,
    input wire logic                 i_sck,
    input wire logic                 i_cs_n,
    input wire logic                 i_data_req,
    input wire logic                 o_so_oe,
    input wire logic                 o_cmd_valid,
    input wire logic [7:0]           o_opcode,
    input wire logic [PAGE_BITS-1:0] o_page_addr_bit,
    input wire logic [2:0]           o_extra_dummy,
    input wire logic                 o_buffer_only,
    input wire logic                 o_mode3,
    input wire logic                 o_standby
);
    logic [5:0] por_cnt_q;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) por_cnt_q <= 6'h00;
        else if (por_cnt_q != 6'h3F) por_cnt_q <= por_cnt_q + 6'h01;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_mode_rst; $rose(i_rst_n) |-> o_mode3 [*4]; endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("mode");
    property p_so_oe; o_so_oe |-> $past(i_data_req); endproperty
    a_so_oe: assert property (p_so_oe) else $error("so oe");
    property p_pulse; o_cmd_valid |=> !o_cmd_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse");
    property p_por; por_cnt_q < SELECT_WAIT |-> !o_cmd_valid && !o_standby;
    endproperty
    a_por: assert property (p_por) else $error("por");
    property p_pick; $fell(i_cs_n) && o_standby |-> ##6 o_mode3 == i_sck;
    endproperty
    a_pick: assert property (p_pick) else $error("pick");
    property p_bpage; o_cmd_valid && o_buffer_only |-> o_page_addr_bit == 0;
    endproperty
    a_bpage: assert property (p_bpage) else $error("bpage");
    property p_bset; o_cmd_valid |-> o_buffer_only == (o_opcode inside
        {8'h84, 8'h87, 8'hD1, 8'hD3, 8'hD4, 8'hD6}); endproperty
    a_bset: assert property (p_bset) else $error("bset");
    property p_dum; o_cmd_valid && o_opcode == 8'hD2 |-> o_extra_dummy == 3'h4;
    endproperty
    a_dum: assert property (p_dum) else $error("dummy");
endmodule : flash_cmd_front_assertions
bind flash_cmd_front flash_cmd_front_assertions #(
    .SELECT_WAIT(SELECT_WAIT), .PROGRAM_WAIT(PROGRAM_WAIT)) chk (.*);
`default_nettype wire

// file: dv/serial_flash_cmd_addr_por_test.sv
`timescale 1ns/100ps
`default_nettype none
module serial_flash_cmd_addr_por_test;
    typedef struct packed {
        logic [7:0] op; logic [10:0] pg; logic [8:0] by;
        logic bo; logic [2:0] xd; logic m;
    } row_type;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_data_req = 1'b0;
    logic cs_n, sck, si, so, so_oe, vld, bo, m3, stby, pok;
    logic [7:0] op;
    logic [10:0] pg;
    logic [8:0] by;
    logic [2:0] xd;
    int failures = 0, check_count = 0, n, oe_n;
    row_type rows [10] = '{
        '{8'h82, 11'h7FF, 9'h1FF, 1'b0, 3'h0, 1'b1},
        '{8'h84, 11'h555, 9'h0AB, 1'b1, 3'h0, 1'b0},
        '{8'h0B, 11'h001, 9'h100, 1'b0, 3'h1, 1'b1},
        '{8'h1B, 11'h400, 9'h001, 1'b0, 3'h2, 1'b0},
        '{8'hD2, 11'h2AA, 9'h155, 1'b0, 3'h4, 1'b1},
        '{8'hD1, 11'h7FF, 9'h0F0, 1'b1, 3'h0, 1'b0},
        '{8'hD3, 11'h00F, 9'h10F, 1'b1, 3'h0, 1'b1},
        '{8'hD4, 11'h7FF, 9'h000, 1'b1, 3'h1, 1'b0},
        '{8'hD6, 11'h0F0, 9'h1FE, 1'b1, 3'h1, 1'b1},
        '{8'h87, 11'h123, 9'h0FF, 1'b1, 3'h0, 1'b0}};
    always #12.5 i_mclk = ~i_mclk;
    spi_host_model host (.o_cs_n(cs_n), .o_sck(sck), .o_si(si));
    flash_cmd_front #(.SELECT_WAIT(8), .PROGRAM_WAIT(20)) DUT (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sck(sck), .i_cs_n(cs_n),
        .i_si(si), .i_data_req(i_data_req), .o_so(so), .o_so_oe(so_oe),
        .o_cmd_valid(vld), .o_opcode(op), .o_page_addr_bit(pg),
        .o_byte_addr(by), .o_extra_dummy(xd), .o_buffer_only(bo),
        .o_mode3(m3), .o_standby(stby), .o_program_ok(pok));
    task automatic chk(input string s, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            $display("MISMATCH %s expected %0h seen %0h", s, e, g);
            failures++;
        end
    endtask : chk
    task automatic send(input logic m, input logic [31:0] w);
        n = 0;
        oe_n = 0;
        fork
            host.frame(m, w);
            repeat (70) @(negedge i_mclk) begin
                if (vld === 1'b1) n++;
                if (so_oe === 1'b1) oe_n++;
            end
        join
    endtask : send
    task automatic results;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    initial begin
        #100us;
        failures++;
        results();
    end
    initial begin
        repeat (2) @(posedge i_mclk);
        chk("mode3", 1, m3);
        chk("so_oe", 0, so_oe);
        chk("standby", 0, {stby, pok});
        i_rst_n <= 1'b1;
        send(1'b1, 32'h82AFFFFF);
        chk("por_pulses", 0, n);
        chk("por_so_oe", 0, oe_n);
        repeat (40) @(posedge i_mclk);
        chk("ready", 3, {stby, pok});
        foreach (rows[i]) begin
            @(posedge i_mclk);
            i_data_req <= (rows[i].xd != 3'h0);
            send(rows[i].m, {rows[i].op, {4{rows[i].m}}, rows[i].pg,
                rows[i].by});
            chk("pulses", 1, n);
            chk("opcode", rows[i].op, op);
            chk("page", rows[i].bo ? 11'h0 : rows[i].pg, pg);
            chk("byte", rows[i].by, by);
            chk("buf", rows[i].bo, bo);
            chk("xdummy", rows[i].xd, xd);
            chk("mode", rows[i].m, m3);
            chk("so_oe_used", rows[i].xd != 3'h0, oe_n != 0);
            chk("so", 0, so);
        end
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(negedge i_mclk);
        chk("mode3_again", 1, m3);
        chk("so_oe_again", 0, so_oe);
        chk("standby_again", 0, {stby, pok});
        repeat (40) @(posedge i_mclk);
        send(rows[0].m, {rows[0].op, 4'h5, rows[0].pg, rows[0].by});
        chk("pulses_again", 1, n);
        chk("page_again", rows[0].pg, pg);
        results();
    end
endmodule : serial_flash_cmd_addr_por_test
`default_nettype wire
